// file: src/tpc_timer_front.sv
`timescale 1ns/1ps

// Function
// - Unused timer pins are GPIO, direction register.
// - Port data read returns real pin levels.
// - Compare-owned pin data latched, driven later.
// - Port data write can trigger capture.
// - Accumulator and clock pins readable status.
// - PWM pins forced as general outputs.
// - Nine-stage prescaler, taps two to 512.
// - Two muxes pick tap or external clock.
// - Reset clocks: capture div four, PWM two.
// - PWM select free; capture select write-once outside test/freeze.
// - Prescaler readable, freeze-writable, bits 8:0.
// - Selected clocks output, one-cycle high pulses.
// - Accumulator gets div512, external, capture clock.
// - Capture counter free-running, unstoppable.
// - Counter resets zero, loads only test/freeze.
// - Wrap sets overflow flag, optional request.
// - Selected edge latches counter, sets flag.
// - Edge field picks rise, fall, both, off.
// - Channels independent, may latch same count.
// - Capture flag requests only when enabled.
// - Inputs synchronised and filtered before capture.
// - Every edge overwrites latch despite flag.
// - Flag clears by read then zero write.
module tpc_timer_front #(
    parameter int NUM_CAP = 4
) (
    input  wire logic                  sys_clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    input  wire logic                  freeze_i,
    input  wire logic                  test_i,
    input  wire tpc_pkg::tpc_bus_req_s bus_i,
    output logic [15:0]                bus_rdata_o,
    input  wire logic [7:0]            gp_pin_i,
    output logic [7:0]                 gp_pin_o,
    output logic [7:0]                 gp_oe_o,
    input  wire logic [3:0]            oc_active_i,
    input  wire logic [3:0]            oc_level_i,
    input  wire logic                  pai_pin_i,
    input  wire logic                  pclk_pin_i,
    input  wire logic [1:0]            pwm_wave_i,
    output logic [1:0]                 pwm_o,
    output tpc_pkg::tpc_ticks_s        ticks_o,
    output logic                       irq_o
);
    import tpc_pkg::*;

    // The capture pins share the low port bits with the compare pins above.
    if (NUM_CAP < 1 || NUM_CAP > OC_BASE) begin : g_chk
        $error("NUM_CAP must lie between 1 and 4.");
    end

    // Picks the tick of one divider tap, or the external clock tick.
    function automatic logic tap_pick(input logic [2:0] sel,
                                      input logic [8:0] taps,
                                      input logic       ext);
        tap_pick = (sel == SEL_PCLK) ? ext : taps[sel];
    endfunction

    function automatic logic hit(input logic [4:0] off);
        hit = (bus_i.addr == off);
    endfunction

    logic [7:0]         pdata_r;
    logic [7:0]         pdir_r;
    logic [NUM_CAP-1:0] mask1_r;
    logic [2:0]         csel_r;
    logic               cout_r;
    logic               ovie_r;
    logic               csel_done_r;
    logic [2:0]         psel_r;
    logic               pout_r;
    logic [1:0]         f1_r;
    logic [1:0]         fpwm_r;
    logic [2*NUM_CAP-1:0] edge_r;
    logic [PRESC_W-1:0] presc_r;
    logic [15:0]        cnt_r;
    logic [NUM_CAP-1:0] fl1_r;
    logic [NUM_CAP-1:0] arm1_r;
    logic               ovf_r;
    logic               arm2_r;
    logic [15:0]        cap_r [NUM_CAP];
    logic [7:0]         gp_s1_r;
    logic [7:0]         gp_s2_r;
    logic [1:0]         ms_s1_r;
    logic [1:0]         ms_s2_r;
    logic               pclk_d_r;
    logic [NUM_CAP-1:0] smp_r;
    logic [NUM_CAP-1:0] filt_r;
    logic [NUM_CAP-1:0] filt_d_r;

    // Bus strobes, decoded once.
    logic wr_pdata, wr_pdir, wr_mask1, wr_mask2, wr_flag1, wr_flag2;
    logic wr_ctl2, wr_cnt, wr_presc, wr_fpwm, rd_flag1, rd_flag2;
    logic test_frz;
    assign wr_pdata = bus_i.wr && hit(OFF_PDATA);
    assign wr_pdir  = bus_i.wr && hit(OFF_PDIR);
    assign wr_mask1 = bus_i.wr && hit(OFF_MASK1);
    assign wr_mask2 = bus_i.wr && hit(OFF_MASK2);
    assign wr_flag1 = bus_i.wr && hit(OFF_FLAG1);
    assign wr_flag2 = bus_i.wr && hit(OFF_FLAG2);
    assign wr_ctl2  = bus_i.wr && hit(OFF_CTL2);
    assign wr_cnt   = bus_i.wr && hit(OFF_CNT);
    assign wr_presc = bus_i.wr && hit(OFF_PRESC);
    assign wr_fpwm  = bus_i.wr && hit(OFF_FPWM);
    assign rd_flag1 = bus_i.rd && hit(OFF_FLAG1);
    assign rd_flag2 = bus_i.rd && hit(OFF_FLAG2);
    assign test_frz = test_i || freeze_i;

    // Each tap ticks once per period: tap k divides by 2 to the k+1.
    logic [8:0] taps;
    logic       pclk_tick;
    logic       cap_tick;
    logic       pwm_tick;
    for (genvar k = 0; k < PRESC_W; k++) begin : g_tap
        assign taps[k] = &presc_r[k:0];
    end
    assign pclk_tick = ms_s2_r[1] && !pclk_d_r;
    assign cap_tick  = tap_pick(csel_r, taps, pclk_tick);
    assign pwm_tick  = tap_pick(psel_r, taps, pclk_tick);

    // Counter and overflow event.
    logic        ovf_evt;
    logic [15:0] cnt_nxt;
    assign ovf_evt = cap_tick && (cnt_r == 16'hFFFF);
    assign cnt_nxt = (wr_cnt && test_frz) ? bus_i.wdata
                   : cnt_r + {15'h0000, cap_tick};

    // Capture source: a pin driven by the port follows the written data,
    // so a write changes the capture input without waiting on the pad.
    logic [NUM_CAP-1:0] cap_src;
    logic [NUM_CAP-1:0] cap_hit;
    for (genvar i = 0; i < NUM_CAP; i++) begin : g_cap
        logic rise;
        logic fall;
        assign cap_src[i] = pdir_r[i] ? pdata_r[i] : gp_s2_r[i];
        assign rise = filt_r[i] && !filt_d_r[i];
        assign fall = !filt_r[i] && filt_d_r[i];
        assign cap_hit[i] = (edge_r[2*i] && rise)
                         || (edge_r[2*i+1] && fall);
    end

    // Flags: the set wins, and an event after the read disarms the clear.
    logic [NUM_CAP-1:0] fl1_clr;
    logic [NUM_CAP-1:0] fl1_nxt;
    logic [NUM_CAP-1:0] arm1_nxt;
    logic               ovf_clr;
    logic               ovf_nxt;
    logic               arm2_nxt;
    assign fl1_clr  = {NUM_CAP{wr_flag1}} & ~bus_i.wdata[NUM_CAP-1:0]
                    & arm1_r;
    assign fl1_nxt  = cap_hit | (fl1_r & ~fl1_clr);
    assign arm1_nxt = (rd_flag1 ? fl1_r
                    : (wr_flag1 ? '0 : arm1_r)) & ~cap_hit;
    assign ovf_clr  = wr_flag2 && !bus_i.wdata[FLAG2_OVF] && arm2_r;
    assign ovf_nxt  = ovf_evt || (ovf_r && !ovf_clr);
    assign arm2_nxt = (rd_flag2 ? ovf_r
                    : (wr_flag2 ? 1'b0 : arm2_r)) && !ovf_evt;

    // Pin drive: unless cout_r puts the capture tick on pin OC_BASE, compare-owned pins follow the compare logic while it
    // is active, so port writes only sit in the latch meanwhile.
    logic [7:0] pin_nxt;
    logic [7:0] oe_nxt;
    for (genvar p = 0; p < 8; p++) begin : g_pin
        if (p >= OC_BASE) begin : g_oc
            logic own;
            assign own = oc_active_i[p-OC_BASE];
            if (p == OC_BASE) begin : g_oc1
                assign pin_nxt[p] = cout_r ? cap_tick
                                  : own ? oc_level_i[p-OC_BASE]
                                  : pdata_r[p];
                assign oe_nxt[p] = pdir_r[p] || cout_r;
            end else begin : g_ocn
                assign pin_nxt[p] = own ? oc_level_i[p-OC_BASE]
                                  : pdata_r[p];
                assign oe_nxt[p] = pdir_r[p];
            end
        end else begin : g_io
            assign pin_nxt[p] = pdata_r[p];
            assign oe_nxt[p]  = pdir_r[p];
        end
    end

    // PWM pins: a set force bit replaces the waveform by the force level, except on pin 0 while pout_r gives the PWM tick.
    logic [1:0] pwm_nxt;
    assign pwm_nxt[0] = pout_r ? pwm_tick
                      : (fpwm_r[0] ? f1_r[0] : pwm_wave_i[0]);
    assign pwm_nxt[1] = fpwm_r[1] ? f1_r[1] : pwm_wave_i[1];

    // Read multiplexer; unmapped words read as zero.
    logic [15:0] rmux;
    always_comb begin
        rmux = 16'h0000;
        case (bus_i.addr)
            OFF_PDATA: rmux[7:0] = gp_s2_r;
            OFF_PDIR:  rmux[7:0] = pdir_r;
            OFF_MASK1: rmux[NUM_CAP-1:0] = mask1_r;
            OFF_MASK2: begin
                rmux[MASK2_CSEL +: 3] = csel_r;
                rmux[MASK2_COUT] = cout_r;
                rmux[MASK2_OVIE] = ovie_r;
            end
            OFF_FLAG1: rmux[NUM_CAP-1:0] = fl1_r;
            OFF_FLAG2: rmux[FLAG2_OVF] = ovf_r;
            OFF_CTL2:  rmux[2*NUM_CAP-1:0] = edge_r;
            OFF_PULSE_ACCUM_CONTROL_REGISTER: begin
                rmux[PULSE_ACCUM_CONTROL_REGISTER_ACCUM_INPUT_PIN_STATE] = ms_s2_r[0];
                rmux[PULSE_ACCUM_CONTROL_REGISTER_PCKS] = ms_s2_r[1];
            end
            OFF_CNT:   rmux = cnt_r;
            OFF_PRESC: rmux[PRESC_W-1:0] = presc_r;
            OFF_FPWM: begin
                rmux[PWM_CONTROL_REGISTER_PSEL +: 3] = psel_r;
                rmux[PWM_CONTROL_REGISTER_POUT] = pout_r;
                rmux[PWM_CONTROL_REGISTER_F1 +: 2] = f1_r;
                rmux[CFRC_FPWM +: 2] = fpwm_r;
            end
            default: begin
                for (int c = 0; c < NUM_CAP; c++) begin
                    if (bus_i.addr == OFF_CAP0 + 5'(c)) begin
                        rmux = cap_r[c];
                    end
                end
            end
        endcase
    end

    // Pin synchronisers; only the second stage is read by logic.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            gp_s1_r  <= 8'h00;
            gp_s2_r  <= 8'h00;
            ms_s1_r  <= 2'h0;
            ms_s2_r  <= 2'h0;
            pclk_d_r <= 1'b0;
        end else if (ce_i) begin
            gp_s1_r  <= gp_pin_i;
            gp_s2_r  <= gp_s1_r;
            ms_s1_r  <= {pclk_pin_i, pai_pin_i};
            ms_s2_r  <= ms_s1_r;
            pclk_d_r <= ms_s2_r[1];
        end
    end

    // Filter: a level is accepted once two samples in a row agree, so a
    // glitch under one clock never reaches the edge detector.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            smp_r    <= '0;
            filt_r   <= '0;
            filt_d_r <= '0;
        end else if (ce_i) begin
            smp_r    <= cap_src;
            filt_r   <= (cap_src & smp_r) | (filt_r & (cap_src | smp_r));
            filt_d_r <= filt_r;
        end
    end

    // Capture latches; every edge overwrites, flag or not, and all
    // channels see the same count in one cycle.
    for (genvar i = 0; i < NUM_CAP; i++) begin : g_latch
        always_ff @(posedge sys_clk_i or posedge rst_i) begin
            if (rst_i) begin
                cap_r[i] <= CNT_RST;
            end else if (ce_i && cap_hit[i]) begin
                cap_r[i] <= cnt_r;
            end
        end
    end

    // Prescaler, counter and flags; the counter has no stop control.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            presc_r <= '0;
            cnt_r   <= CNT_RST;
            fl1_r   <= '0;
            arm1_r  <= '0;
            ovf_r   <= 1'b0;
            arm2_r  <= 1'b0;
        end else if (ce_i) begin
            presc_r <= (wr_presc && freeze_i)
                     ? bus_i.wdata[PRESC_W-1:0]
                     : presc_r + 9'h001;
            cnt_r   <= cnt_nxt;
            fl1_r   <= fl1_nxt;
            arm1_r  <= arm1_nxt;
            ovf_r   <= ovf_nxt;
            arm2_r  <= arm2_nxt;
        end
    end

    // Control registers. Outside test and freeze the capture clock select takes one write only,
    // so a stray store cannot retime a running capture base.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pdata_r     <= 8'h00;
            pdir_r      <= 8'h00;
            mask1_r     <= '0;
            csel_r      <= CSEL_RST;
            cout_r      <= 1'b0;
            ovie_r      <= 1'b0;
            csel_done_r <= 1'b0;
            psel_r      <= PSEL_RST;
            pout_r      <= 1'b0;
            f1_r        <= 2'h0;
            fpwm_r      <= 2'h0;
            edge_r      <= '0;
        end else if (ce_i) begin
            if (wr_pdata) begin
                pdata_r <= bus_i.wdata[7:0];
            end
            if (wr_pdir) begin
                pdir_r <= bus_i.wdata[7:0];
            end
            if (wr_mask1) begin
                mask1_r <= bus_i.wdata[NUM_CAP-1:0];
            end
            if (wr_mask2) begin
                cout_r      <= bus_i.wdata[MASK2_COUT];
                ovie_r      <= bus_i.wdata[MASK2_OVIE];
                csel_done_r <= 1'b1;
                if (!csel_done_r || test_frz) begin
                    csel_r <= bus_i.wdata[MASK2_CSEL +: 3];
                end
            end
            if (wr_fpwm) begin
                psel_r <= bus_i.wdata[PWM_CONTROL_REGISTER_PSEL +: 3];
                pout_r <= bus_i.wdata[PWM_CONTROL_REGISTER_POUT];
                f1_r   <= bus_i.wdata[PWM_CONTROL_REGISTER_F1 +: 2];
                fpwm_r <= bus_i.wdata[CFRC_FPWM +: 2];
            end
            if (wr_ctl2) begin
                edge_r <= bus_i.wdata[2*NUM_CAP-1:0];
            end
        end
    end

    // Registered outputs, driven straight from these flops.
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bus_rdata_o <= 16'h0000;
            gp_pin_o    <= 8'h00;
            gp_oe_o     <= 8'h00;
            pwm_o       <= 2'h0;
            ticks_o     <= '0;
            irq_o       <= 1'b0;
        end else if (ce_i) begin
            if (bus_i.rd) begin
                bus_rdata_o <= rmux;
            end
            gp_pin_o <= pin_nxt;
            gp_oe_o  <= oe_nxt;
            pwm_o    <= pwm_nxt;
            ticks_o  <= '{cap: cap_tick, pwm: pwm_tick,
                          div512: taps[8], pclk: pclk_tick};
            irq_o    <= (|(fl1_r & mask1_r))
                     || (ovf_r && ovie_r);
        end
    end

endmodule

// file: src/tpc_pkg.sv
package tpc_pkg;

    // Register word indices on the internal module bus.
    localparam logic [4:0] OFF_PDATA = 5'h00;
    localparam logic [4:0] OFF_PDIR  = 5'h01;
    localparam logic [4:0] OFF_MASK1 = 5'h02;
    localparam logic [4:0] OFF_MASK2 = 5'h03;
    localparam logic [4:0] OFF_FLAG1 = 5'h04;
    localparam logic [4:0] OFF_FLAG2 = 5'h05;
    localparam logic [4:0] OFF_CTL2  = 5'h06;
    localparam logic [4:0] OFF_PULSE_ACCUM_CONTROL_REGISTER = 5'h07;
    localparam logic [4:0] OFF_CNT   = 5'h08;
    localparam logic [4:0] OFF_PRESC = 5'h09;
    localparam logic [4:0] OFF_FPWM  = 5'h0A;
    localparam logic [4:0] OFF_CAP0  = 5'h0C;

    // Field positions.
    localparam int MASK2_CSEL = 0;
    localparam int MASK2_COUT = 3;
    localparam int MASK2_OVIE = 7;
    localparam int FLAG2_OVF  = 7;
    localparam int PWM_CONTROL_REGISTER_PSEL  = 0;
    localparam int PWM_CONTROL_REGISTER_POUT  = 3;
    localparam int PWM_CONTROL_REGISTER_F1    = 4;
    localparam int CFRC_FPWM  = 14;
    localparam int PULSE_ACCUM_CONTROL_REGISTER_ACCUM_INPUT_PIN_STATE = 15;
    localparam int PULSE_ACCUM_CONTROL_REGISTER_PCKS = 14;

    // Geometry and reset values.
    localparam int         PRESC_W    = 9;
    localparam int         OC_BASE    = 4;
    localparam logic [2:0] CSEL_RST   = 3'h1;
    localparam logic [2:0] PSEL_RST   = 3'h0;
    localparam logic [2:0] SEL_PCLK   = 3'h7;
    localparam logic [15:0] CNT_RST   = 16'h0000;
    localparam logic [1:0] EDGE_RISE  = 2'h1;
    localparam logic [1:0] EDGE_FALL  = 2'h2;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } tpc_bus_req_s;

    typedef struct packed {
        logic cap;
        logic pwm;
        logic div512;
        logic pclk;
    } tpc_ticks_s;

endpackage

// file: tb/tpc_pin_model.sv
`timescale 1ns/1ps

// Outside world of the timer pins: resolves each two-way pin from both ends.
module tpc_pin_model (
    input  wire logic [7:0] pin_o_i,
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] ext_i,
    output logic [7:0]      level_o
);
    // The device wins wherever its enable is high. The bench always drives
    // the others, so a floating pin never has to be modelled here.
    assign level_o = (oe_i & pin_o_i) | (~oe_i & ext_i);
endmodule

// file: tb/tpc_checker.sv
`timescale 1ns/1ps

module tpc_checker
    import tpc_pkg::*;
#(
    parameter int NUM_CAP = 4
) (
    input wire logic                  sys_clk_i,
    input wire logic                  rst_i,
    input wire logic                  ce_i,
    input wire logic                  freeze_i,
    input wire logic                  test_i,
    input wire tpc_pkg::tpc_bus_req_s bus_i,
    input wire logic [15:0]           bus_rdata_o,
    input wire logic [7:0]            gp_pin_i,
    input wire logic [7:0]            gp_pin_o,
    input wire logic [7:0]            gp_oe_o,
    input wire logic [3:0]            oc_active_i,
    input wire logic [3:0]            oc_level_i,
    input wire logic                  pai_pin_i,
    input wire logic                  pclk_pin_i,
    input wire logic [1:0]            pwm_wave_i,
    input wire logic [1:0]            pwm_o,
    input wire tpc_pkg::tpc_ticks_s   ticks_o,
    input wire logic                  irq_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    // Read strobe that the design takes, gated by the clock enable.
    wire rd_ok = bus_i.rd && ce_i;

    property p_presc_hi;
        rd_ok && bus_i.addr == OFF_PRESC |=> bus_rdata_o[15:9] == 7'h00;
    endproperty
    a_presc_hi: assert property (p_presc_hi)
        else $error("prescaler upper bits not zero");

    // Pins must have been steady long enough to pass the synchroniser.
    property p_pins_read;
        rd_ok && bus_i.addr == OFF_PDATA && $stable(gp_pin_i)
        && $past(gp_pin_i, 2) == gp_pin_i
        |=> bus_rdata_o[7:0] == $past(gp_pin_i);
    endproperty
    a_pins_read: assert property (p_pins_read)
        else $error("port data read differs from pins");

    property p_pai_read;
        rd_ok && bus_i.addr == OFF_PULSE_ACCUM_CONTROL_REGISTER && $stable(pai_pin_i)
        && $past(pai_pin_i, 2) == pai_pin_i
        |=> bus_rdata_o[PULSE_ACCUM_CONTROL_REGISTER_ACCUM_INPUT_PIN_STATE] == $past(pai_pin_i);
    endproperty
    a_pai_read: assert property (p_pai_read)
        else $error("accumulator pin state wrong");

    property p_pclk_read;
        rd_ok && bus_i.addr == OFF_PULSE_ACCUM_CONTROL_REGISTER && $stable(pclk_pin_i)
        && $past(pclk_pin_i, 2) == pclk_pin_i
        |=> bus_rdata_o[PULSE_ACCUM_CONTROL_REGISTER_PCKS] == $past(pclk_pin_i);
    endproperty
    a_pclk_read: assert property (p_pclk_read)
        else $error("clock pin state wrong");

    property p_cap_tick;
        ticks_o.cap && ce_i |=> !ticks_o.cap;
    endproperty
    a_cap_tick: assert property (p_cap_tick)
        else $error("capture tick longer than one cycle");

    property p_pwm_tick;
        ticks_o.pwm && ce_i |=> !ticks_o.pwm;
    endproperty
    a_pwm_tick: assert property (p_pwm_tick)
        else $error("pwm tick longer than one cycle");

    property p_div512;
        ticks_o.div512 && ce_i |=> !ticks_o.div512 [*8];
    endproperty
    a_div512: assert property (p_div512)
        else $error("div512 tick too close");

    // A low enable must freeze the read data, the pin enables and the PWM outputs.
    property p_ce_hold;
        !ce_i |=> $stable(bus_rdata_o) && $stable(gp_oe_o) && $stable(pwm_o);
    endproperty
    a_ce_hold: assert property (p_ce_hold)
        else $error("outputs moved with clock enable low");
endmodule

bind tpc_timer_front tpc_checker #(.NUM_CAP(NUM_CAP)) tpc_checker_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .freeze_i(freeze_i),
    .test_i(test_i), .bus_i(bus_i), .bus_rdata_o(bus_rdata_o),
    .gp_pin_i(gp_pin_i), .gp_pin_o(gp_pin_o), .gp_oe_o(gp_oe_o),
    .oc_active_i(oc_active_i), .oc_level_i(oc_level_i),
    .pai_pin_i(pai_pin_i), .pclk_pin_i(pclk_pin_i),
    .pwm_wave_i(pwm_wave_i), .pwm_o(pwm_o), .ticks_o(ticks_o), .irq_o(irq_o));

// file: tb/tb.sv
`timescale 1ns/1ps

module tb;
    import tpc_pkg::*;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    logic         ce = 1'b1;
    logic         frz = 1'b0;
    logic         tst = 1'b0;
    tpc_bus_req_s bus = '0;
    logic [15:0]  rdata;
    logic [7:0]   pins;
    logic [7:0]   pin_o;
    logic [7:0]   oe;
    logic [7:0]   ext = 8'h00;
    logic [3:0]   oc_act = 4'h0;
    logic [1:0]   wave = 2'h0;
    logic [1:0]   pwm;
    logic         pulse_accum_input_pin = 1'b0;
    logic         pclk = 1'b0;
    logic         irq;
    tpc_ticks_s   ticks;
    int           err_count = 0;
    int           samples_checked = 0;
    int           c;
    int           n;
    logic [15:0]  d, a, b;

    // Half period of 4 ns gives the 125 MHz system clock.
    always #4 clk = ~clk;

    tpc_timer_front tpc_timer_front_inst (
        .sys_clk_i(clk), .rst_i(rst), .ce_i(ce), .freeze_i(frz),
        .test_i(tst), .bus_i(bus), .bus_rdata_o(rdata), .gp_pin_i(pins),
        .gp_pin_o(pin_o), .gp_oe_o(oe), .oc_active_i(oc_act),
        .oc_level_i(4'h0), .pai_pin_i(pulse_accum_input_pin), .pclk_pin_i(pclk),
        .pwm_wave_i(wave), .pwm_o(pwm), .ticks_o(ticks), .irq_o(irq));

    tpc_pin_model tpc_pin_model_inst (
        .pin_o_i(pin_o), .oe_i(oe), .ext_i(ext), .level_o(pins));

    task automatic close_out();
        if (err_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle strobes, raised and dropped on falling edges.
    task automatic wr(input logic [4:0] ad, input logic [15:0] wd);
        @(negedge clk);
        bus.wr = 1'b1;
        bus.addr = ad;
        bus.wdata = wd;
        @(negedge clk);
        bus.wr = 1'b0;
    endtask

    task automatic rd(input logic [4:0] ad, output logic [15:0] rv);
        @(negedge clk);
        bus.rd = 1'b1;
        bus.addr = ad;
        @(negedge clk);
        bus.rd = 1'b0;
        rv = rdata;
    endtask

    // Counts high cycles of one chosen output over a fixed window.
    task automatic count(input int sel, input int n, output int k);
        k = 0;
        repeat (n) begin
            @(negedge clk);
            case (sel)
                0: k += (ticks.pwm === 1'b1);
                1: k += (ticks.div512 === 1'b1);
                2: k += (pin_o[4] === 1'b1);
                4: k += (ticks.pclk === 1'b1);
                5: k += (ticks.cap === 1'b1);
                default: k += (pwm[0] === 1'b1);
            endcase
        end
    endtask

    task automatic wait_irq(input logic e);
        int i;
        for (i = 0; i < 20 && irq !== e; i++) begin
            @(negedge clk);
        end
        if (irq !== e) begin
            err_count++;
            $display("Error %0t: interrupt wait timed out", $time);
            close_out();
        end
    endtask

    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rd(OFF_CNT, d);
        chk(d, 16'h0000);
        count(0, 40, c);
        chk(16'(c), 16'd20);
        // Counter steps every four cycles; a plain write must not load it.
        rd(OFF_CNT, a);
        wr(OFF_CNT, 16'h5555);
        repeat (36) @(negedge clk);
        rd(OFF_CNT, d);
        chk(d, a + 16'd10);
        tst = 1'b1;
        wr(OFF_CNT, 16'hFFF0);
        tst = 1'b0;
        rd(OFF_CNT, d);
        chk(d & 16'hFFF0, 16'hFFF0);
        wr(OFF_MASK2, 16'h0081);
        repeat (80) @(negedge clk);
        rd(OFF_FLAG2, d);
        chk(d & 16'h0080, 16'h0080);
        chk({15'h0, irq}, 16'h0001);
        wr(OFF_FLAG2, 16'h0000);
        rd(OFF_FLAG2, d);
        chk(d & 16'h0080, 16'h0000);
        wr(OFF_MASK2, 16'h0000);
        rd(OFF_MASK2, d);
        chk(d & 16'h0007, 16'h0001);
        // Clock outputs: one-cycle highs at the selected rate.
        wr(OFF_MASK2, 16'h0008);
        count(2, 40, c);
        chk(16'(c), 16'd10);
        count(5, 40, c);
        chk(16'(c), 16'd10);
        wr(OFF_MASK2, 16'h0000);
        wr(OFF_FPWM, 16'h0008);
        count(3, 40, c);
        chk(16'(c), 16'd20);
        for (int k = 0; k < 7; k++) begin
            wr(OFF_FPWM, 16'(k));
            count(0, 256, c);
            chk(16'(c), 16'(256 >> (k + 1)));
        end
        wr(OFF_FPWM, 16'(SEL_PCLK));
        fork
            count(0, 60, c);
            count(4, 60, n);
            repeat (3) begin
                repeat (5) @(negedge clk);
                pclk = 1'b1;
                repeat (5) @(negedge clk);
                pclk = 1'b0;
            end
        join
        chk(16'(c), 16'd3);
        chk(16'(n), 16'd3);
        count(1, 1024, c);
        chk(16'(c), 16'd2);
        wr(OFF_FPWM, 16'hC030);
        repeat (2) @(negedge clk);
        chk({14'h0, pwm}, 16'h0003);
        wr(OFF_FPWM, 16'hC000);
        wave = 2'h2;
        repeat (2) @(negedge clk);
        chk({14'h0, pwm}, 16'h0000);
        wr(OFF_FPWM, 16'h0000);
        repeat (2) @(negedge clk);
        chk({14'h0, pwm}, 16'h0002);
        // Captures: ch0 rise, ch1 fall, ch2 both, ch3 off.
        wr(OFF_CTL2, 16'h0039);
        wr(OFF_MASK1, 16'h0002);
        @(negedge clk);
        ext = 8'h0F;
        #3 ext = 8'h00;
        repeat (10) @(negedge clk);
        rd(OFF_FLAG1, d);
        chk(d & 16'h000F, 16'h0000);
        ext = 8'h0F;
        repeat (10) @(negedge clk);
        rd(OFF_FLAG1, d);
        chk(d & 16'h000F, 16'h0005);
        chk({15'h0, irq}, 16'h0000);
        rd(OFF_CAP0, a);
        rd(OFF_CAP0 + 5'h2, b);
        chk(b, a);
        ext = 8'h00;
        wait_irq(1'b1);
        repeat (10) @(negedge clk);
        rd(OFF_FLAG1, d);
        chk(d & 16'h000F, 16'h0007);
        rd(OFF_CAP0 + 5'h1, b);
        rd(OFF_CAP0 + 5'h2, d);
        chk(d, b);
        rd(OFF_CAP0, d);
        chk(d, a);
        wr(OFF_FLAG1, 16'h0000);
        wait_irq(1'b0);
        // A port write on an output capture pin makes its own edge.
        wr(OFF_PDIR, 16'h0001);
        wr(OFF_PDATA, 16'h0001);
        ext = 8'h22;
        repeat (10) @(negedge clk);
        rd(OFF_FLAG1, d);
        chk(d & 16'h0001, 16'h0001);
        chk({8'h0, oe}, 16'h0001);
        rd(OFF_PDATA, d);
        chk(d & 16'h00FF, 16'h0023);
        oc_act = 4'h1;
        wr(OFF_PDIR, 16'h0011);
        wr(OFF_PDATA, 16'h0011);
        repeat (3) @(negedge clk);
        chk({15'h0, pin_o[4]}, 16'h0000);
        oc_act = 4'h0;
        repeat (3) @(negedge clk);
        chk({15'h0, pin_o[4]}, 16'h0001);
        for (int k = 0; k < 2; k++) begin
            pulse_accum_input_pin = 1'(k ^ 1);
            pclk = 1'(k);
            repeat (5) @(negedge clk);
            rd(OFF_PULSE_ACCUM_CONTROL_REGISTER, d);
            chk({14'h0, d[15:14]}, 16'(2 >> k));
        end
        frz = 1'b1;
        wr(OFF_PRESC, 16'h01F0);
        frz = 1'b0;
        rd(OFF_PRESC, d);
        chk(d, 16'h01F1);
        rd(OFF_PRESC, d);
        chk(d & 16'hFE00, 16'h0000);
        ce = 1'b0;
        @(negedge clk);
        ce = 1'b1;
        repeat (4) @(negedge clk);
        close_out();
    end
endmodule
